/* design/hdlcr_cfg.svh */
`ifndef HDLCR_CFG_SVH
`define HDLCR_CFG_SVH

// register byte offsets
`define HDLCR_OFF_CTRL 12'h000
`define HDLCR_OFF_THR 12'h004
`define HDLCR_OFF_STAT 12'h008
`define HDLCR_OFF_DATA 12'h00C
`define HDLCR_OFF_CNT 12'h010

// control fields
`define HDLCR_CTRL_INV 0
`define HDLCR_CTRL_FCS 1
`define HDLCR_CTRL_REV 2
`define HDLCR_CTRL_RST 3'h0

// status fields
`define HDLCR_ST_EMPTY 0
`define HDLCR_ST_AVAIL 1
`define HDLCR_ST_FULL 2
`define HDLCR_ST_OVF 3
`define HDLCR_ST_INVAL 4
`define HDLCR_ST_ABORT 5
`define HDLCR_ST_FCSERR 6
`define HDLCR_ST_LVL 16

// fifo data word fields
`define HDLCR_DW_START 8
`define HDLCR_DW_END 9
`define HDLCR_DW_ABORT 10
`define HDLCR_DW_FCSERR 11
`define HDLCR_DW_EMPTY 15

// line coding
`define HDLCR_FLAG 8'h7E
`define HDLCR_FLAG_BITS 4'h8
`define HDLCR_STUFF_ONES 3'h5
`define HDLCR_ABORT_ONES 3'h6
`define HDLCR_CRC_INIT 16'hFFFF
`define HDLCR_CRC_POLY 16'h8408
`define HDLCR_CRC_GOOD 16'hF0B8

// fifo sizing
`define HDLCR_DEPTH 9'h100
`define HDLCR_RESUME 9'h010
`define HDLCR_THR_RST 9'h010

`endif

/* design/hdlcr_pkg.sv */
package hdlcr_pkg;

  typedef enum logic {
    ST_IDLE,
    ST_OPEN
  } hdlcr_rx_st_t;

  typedef struct packed {
    logic fcs_err;
    logic abort;
    logic pend;
    logic pstart;
    logic [7:0] data;
  } hdlcr_entry_t;

  typedef struct packed {
    logic valid;
    hdlcr_entry_t ent;
  } hdlcr_wr_t;

  typedef struct packed {
    logic reorder;
    logic fcs_en;
    logic invert;
  } hdlcr_ctrl_t;

endpackage : hdlcr_pkg

/* design/hdlcr_top.sv */
`timescale 1ns/100ps
`include "hdlcr_cfg.svh"
// Contract
// R01 - invert line bits before any processing
// R02 - bitwise sliding search for 7Eh flags
// R03 - accept shared, single, double, filled separators
// R04 - discard flag or ones inter-frame fill
// R05 - under 16 bits between flags: discard
// R06 - seven ones: abort packet, drop until flag
// R07 - delete zero after five ones
// R08 - pack bytes with start, end, abort marks
// R09 - short last byte: invalid status, abort
// R10 - trailing five ones end normally
// R11 - FCS on: check, strip two bytes, flag
// R12 - FCS off: forward every byte
// R13 - bit order into FIFO per reorder
// R14 - 256 byte FIFO with per-byte status
// R15 - empty, full, threshold data-available flags
// R16 - empty read: no change, invalid data
// R17 - start byte while full: drop, overflow
// R18 - other byte while full: abort, overflow
// R19 - after overflow resume on start, 16 free
// R20 - byte FIFO, tracks level and pointers
// R21 - CRC-16 x16+x12+x5+1, inverted check value
// R22 - storage readable and writable independently
// R23 - pointers and level cross domains safely
// R24 - good only on fixed CRC residue
module hdlcr_top (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // overhead stream from framer logic
  input wire logic line_bit,
  input wire logic line_bit_en
);

  // ---------------- receive packet processor ----------------
  hdlcr_pkg::hdlcr_rx_st_t st_q, st_d;
  logic [7:0] win_q, win_d;
  logic [3:0] skip_q, skip_d;
  logic bnd_q, bnd_d;
  logic [2:0] ones_q, ones_d;
  logic [2:0] nbits_q, nbits_d;
  logic [1:0] nbytes_q, nbytes_d;
  logic [7:0] asm_q, asm_d;
  logic [7:0] hold_q [0:2];
  logic [7:0] hold_d [0:2];
  logic [1:0] hc_q, hc_d;
  logic emitted_q, emitted_d;
  logic [1:0] flush_q, flush_d;
  logic fl_abort_q, fl_abort_d;
  logic fl_fcserr_q, fl_fcserr_d;
  logic [15:0] crc_q, crc_d;
  hdlcr_pkg::hdlcr_wr_t wr_q, wr_d;
  hdlcr_pkg::hdlcr_ctrl_t ctrl_q, ctrl_d;
  logic inval_set, abort_set, fcserr_set;
  logic rxb, xb;
  logic [7:0] nbyte;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    logic [15:0] n;
    n = {1'b0, c[15:1]};
    if (c[0] ^ b) begin
      n = n ^ `HDLCR_CRC_POLY; // [R21]
    end
    return n;
  endfunction : crc_step

  function automatic hdlcr_pkg::hdlcr_wr_t emit(input logic [7:0] d, input logic rev, input logic s,
                                                input logic e, input logic a, input logic f);
    hdlcr_pkg::hdlcr_wr_t w;
    w.valid = 1'b1;
    // assembled with the first line bit in bit 0
    for (int i = 0; i < 8; i++) begin
      w.ent.data[i] = rev ? d[7 - i] : d[i]; // [R13]
    end
    w.ent.pstart = s;
    w.ent.pend = e;
    w.ent.abort = a;
    w.ent.fcs_err = f;
    return w;
  endfunction : emit

  always_comb begin
    st_d = st_q;
    win_d = win_q;
    skip_d = skip_q;
    bnd_d = bnd_q;
    ones_d = ones_q;
    nbits_d = nbits_q;
    nbytes_d = nbytes_q;
    asm_d = asm_q;
    hold_d = hold_q;
    hc_d = hc_q;
    emitted_d = emitted_q;
    flush_d = flush_q;
    fl_abort_d = fl_abort_q;
    fl_fcserr_d = fl_fcserr_q;
    crc_d = crc_q;
    wr_d = '0;
    inval_set = 1'b0;
    abort_set = 1'b0;
    fcserr_set = 1'b0;
    rxb = line_bit ^ ctrl_q.invert; // [R01]
    xb = win_q[7];
    nbyte = {xb, asm_q[7:1]};
    // drain held bytes at a packet end, one per cycle; new bytes are at least eight bit times away
    if (flush_q != 2'h0) begin
      wr_d = emit(hold_q[0], ctrl_q.reorder, !emitted_q, flush_q == 2'h1,
                  (flush_q == 2'h1) && fl_abort_q, (flush_q == 2'h1) && fl_fcserr_q); // [R08]
      hold_d[0] = hold_q[1];
      hold_d[1] = hold_q[2];
      emitted_d = 1'b1;
      flush_d = flush_q - 2'h1;
      if (flush_q == 2'h1) begin
        // with FCS on the two bytes left behind are the check field
        hc_d = 2'h0; // [R11]
        emitted_d = 1'b0;
      end
    end
    if (line_bit_en) begin
      win_d = {win_q[6:0], rxb};
      skip_d = (skip_q != 4'h0) ? skip_q - 4'h1 : 4'h0;
      if (bnd_q) begin
        // first flag bit leaves the window: close the open packet, open a new one
        bnd_d = 1'b0;
        if (st_q == hdlcr_pkg::ST_OPEN && (nbits_q != 3'h0 || nbytes_q != 2'h0)) begin
          if (nbytes_q != 2'h2) begin
            hc_d = 2'h0; // [R05]
            emitted_d = 1'b0;
          end else if (nbits_q != 3'h0) begin
            inval_set = 1'b1; // [R09]
            abort_set = emitted_q;
            flush_d = emitted_q ? 2'h1 : 2'h0;
            fl_abort_d = 1'b1;
            fl_fcserr_d = 1'b0;
            if (!emitted_q) begin
              hc_d = 2'h0;
            end
          end else if (ctrl_q.fcs_en) begin
            fl_abort_d = 1'b0;
            fl_fcserr_d = crc_q != `HDLCR_CRC_GOOD; // [R24]
            fcserr_set = (hc_q == 2'h3) && (crc_q != `HDLCR_CRC_GOOD); // [R11]
            flush_d = (hc_q == 2'h3) ? 2'h1 : 2'h0;
            if (hc_q != 2'h3) begin
              hc_d = 2'h0;
              emitted_d = 1'b0;
            end
          end else begin
            fl_abort_d = 1'b0;
            fl_fcserr_d = 1'b0;
            flush_d = hc_q; // [R12]
          end
        end
        // a flag right after a flag only reopens, so any separator works
        st_d = hdlcr_pkg::ST_OPEN; // [R03]
        ones_d = 3'h0;
        nbits_d = 3'h0;
        nbytes_d = 2'h0;
        crc_d = `HDLCR_CRC_INIT;
      end else if (skip_q == 4'h0 && st_q == hdlcr_pkg::ST_OPEN) begin
        if (xb && ones_q == `HDLCR_ABORT_ONES) begin
          // seventh one; also swallows ones fill after an end flag
          st_d = hdlcr_pkg::ST_IDLE; // [R06] [R04]
          abort_set = emitted_q;
          flush_d = emitted_q ? 2'h1 : 2'h0;
          fl_abort_d = 1'b1;
          fl_fcserr_d = 1'b0;
          if (!emitted_q) begin
            hc_d = 2'h0;
          end
        end else if (!xb && ones_q == `HDLCR_STUFF_ONES) begin
          ones_d = 3'h0; // [R07] [R10]
        end else begin
          ones_d = xb ? ones_q + 3'h1 : 3'h0;
          crc_d = crc_step(crc_q, xb);
          asm_d = nbyte;
          nbits_d = nbits_q + 3'h1;
          if (nbits_q == 3'h7) begin
            nbytes_d = (nbytes_q == 2'h2) ? 2'h2 : nbytes_q + 2'h1;
            // three bytes held back so the FCS can be stripped and the end mark placed
            if (hc_q == 2'h3) begin
              wr_d = emit(hold_q[0], ctrl_q.reorder, !emitted_q, 1'b0, 1'b0, 1'b0); // [R08]
              emitted_d = 1'b1;
              hold_d[0] = hold_q[1];
              hold_d[1] = hold_q[2];
              hold_d[2] = nbyte;
            end else begin
              hold_d[hc_q] = nbyte;
              hc_d = hc_q + 2'h1;
            end
          end
        end
      end
      // fill and data outside a packet are simply never taken in
      if (win_d == `HDLCR_FLAG) begin
        skip_d = `HDLCR_FLAG_BITS; // [R02] [R04]
        bnd_d = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= hdlcr_pkg::ST_IDLE;
      win_q <= 8'h00;
      skip_q <= 4'h0;
      bnd_q <= 1'b0;
      ones_q <= 3'h0;
      nbits_q <= 3'h0;
      nbytes_q <= 2'h0;
      asm_q <= 8'h00;
      hold_q <= '{default: 8'h00};
      hc_q <= 2'h0;
      emitted_q <= 1'b0;
      flush_q <= 2'h0;
      fl_abort_q <= 1'b0;
      fl_fcserr_q <= 1'b0;
      crc_q <= `HDLCR_CRC_INIT;
      wr_q <= '0;
    end else begin
      st_q <= st_d;
      win_q <= win_d;
      skip_q <= skip_d;
      bnd_q <= bnd_d;
      ones_q <= ones_d;
      nbits_q <= nbits_d;
      nbytes_q <= nbytes_d;
      asm_q <= asm_d;
      hold_q <= hold_d;
      hc_q <= hc_d;
      emitted_q <= emitted_d;
      flush_q <= flush_d;
      fl_abort_q <= fl_abort_d;
      fl_fcserr_q <= fl_fcserr_d;
      crc_q <= crc_d;
      wr_q <= wr_d;
    end
  end

  // ---------------- receive fifo ----------------
  hdlcr_pkg::hdlcr_entry_t mem [0:255];
  logic [8:0] wp_q, wp_d, rp_q, rp_d;
  logic dis_q, dis_d;
  logic [8:0] level, free;
  logic [8:0] thr_q, thr_d;
  logic full, empty, avail, pop, ovf_set;
  logic mem_we;
  logic [7:0] mem_idx;
  hdlcr_pkg::hdlcr_entry_t mem_val;

  // one clock: both pointers live in pclk, so the level needs no crossing
  assign level = wp_q - rp_q; // [R20] [R23]
  assign free = `HDLCR_DEPTH - level;
  assign full = level == `HDLCR_DEPTH; // [R15]
  assign empty = level == 9'h000;
  assign avail = level >= thr_q;

  always_comb begin
    wp_d = wp_q;
    rp_d = pop ? rp_q + 9'h001 : rp_q;
    dis_d = dis_q;
    ovf_set = 1'b0;
    mem_we = 1'b0;
    mem_idx = wp_q[7:0];
    mem_val = wr_q.ent;
    if (wr_q.valid) begin
      if (dis_q) begin
        if (wr_q.ent.pstart && free >= `HDLCR_RESUME) begin
          dis_d = 1'b0; // [R19]
          mem_we = 1'b1;
          wp_d = wp_q + 9'h001;
        end
      end else if (full) begin
        ovf_set = 1'b1; // [R17]
        dis_d = 1'b1;
        if (!wr_q.ent.pstart) begin
          // the newest stored byte becomes an aborted packet end
          mem_idx = wp_q[7:0] - 8'h01; // [R18]
          mem_val = mem[mem_idx];
          mem_val.abort = 1'b1;
          mem_val.pend = 1'b1;
          mem_we = 1'b1;
        end
      end else begin
        mem_we = 1'b1; // [R14]
        wp_d = wp_q + 9'h001;
      end
    end
  end

  // storage is plain flops, written and read without any mutual locking
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_val; // [R22]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= 9'h000;
      rp_q <= 9'h000;
      dis_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      dis_q <= dis_d;
    end
  end

  // ---------------- apb registers ----------------
  logic ovf_q, ovf_d, inval_q, inval_d, abt_q, abt_d, ferr_q, ferr_d;
  logic [15:0] pkt_q, pkt_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d, rd_ok_q, rd_ok_d;
  logic setup, wr_acc, rd_acc, clr;
  hdlcr_pkg::hdlcr_entry_t head;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign clr = wr_acc && paddr == `HDLCR_OFF_STAT;
  assign head = mem[rp_q[7:0]];
  // a pop only follows a setup that saw data
  assign pop = rd_acc && paddr == `HDLCR_OFF_DATA && rd_ok_q; // [R16]
  assign pready = 1'b1;
  assign pslverr = pslverr_q && psel && penable;
  assign prdata = prdata_q;

  always_comb begin
    ctrl_d = ctrl_q;
    thr_d = thr_q;
    pkt_d = (wr_q.valid && wr_q.ent.pend) ? pkt_q + 16'h0001 : pkt_q;
    // a set in the clearing cycle wins
    ovf_d = ovf_set || (ovf_q && !(clr && pwdata[`HDLCR_ST_OVF]));
    inval_d = inval_set || (inval_q && !(clr && pwdata[`HDLCR_ST_INVAL])); // [R09]
    abt_d = abort_set || (abt_q && !(clr && pwdata[`HDLCR_ST_ABORT]));
    ferr_d = fcserr_set || (ferr_q && !(clr && pwdata[`HDLCR_ST_FCSERR]));
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    rd_ok_d = rd_ok_q;
    if (wr_acc && paddr == `HDLCR_OFF_CTRL) begin
      ctrl_d.invert = pwdata[`HDLCR_CTRL_INV];
      ctrl_d.fcs_en = pwdata[`HDLCR_CTRL_FCS];
      ctrl_d.reorder = pwdata[`HDLCR_CTRL_REV];
    end
    if (wr_acc && paddr == `HDLCR_OFF_THR) begin
      thr_d = pwdata[8:0];
    end
    if (wr_acc && paddr == `HDLCR_OFF_CNT) begin
      pkt_d = 16'h0000;
    end
    if (setup) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      rd_ok_d = 1'b0;
      unique case (paddr)
        `HDLCR_OFF_CTRL: begin
          prdata_d[`HDLCR_CTRL_INV] = ctrl_q.invert;
          prdata_d[`HDLCR_CTRL_FCS] = ctrl_q.fcs_en;
          prdata_d[`HDLCR_CTRL_REV] = ctrl_q.reorder;
        end
        `HDLCR_OFF_THR: prdata_d[8:0] = thr_q;
        `HDLCR_OFF_STAT: begin
          prdata_d[`HDLCR_ST_EMPTY] = empty;
          prdata_d[`HDLCR_ST_AVAIL] = avail;
          prdata_d[`HDLCR_ST_FULL] = full;
          prdata_d[`HDLCR_ST_OVF] = ovf_q;
          prdata_d[`HDLCR_ST_INVAL] = inval_q;
          prdata_d[`HDLCR_ST_ABORT] = abt_q;
          prdata_d[`HDLCR_ST_FCSERR] = ferr_q;
          prdata_d[`HDLCR_ST_LVL +: 9] = level;
        end
        `HDLCR_OFF_DATA: begin
          rd_ok_d = !empty;
          if (empty) begin
            prdata_d[`HDLCR_DW_EMPTY] = 1'b1; // [R16]
          end else begin
            prdata_d[7:0] = head.data;
            prdata_d[`HDLCR_DW_START] = head.pstart;
            prdata_d[`HDLCR_DW_END] = head.pend;
            prdata_d[`HDLCR_DW_ABORT] = head.abort;
            prdata_d[`HDLCR_DW_FCSERR] = head.fcs_err;
          end
        end
        `HDLCR_OFF_CNT: prdata_d[15:0] = pkt_q;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `HDLCR_CTRL_RST;
      thr_q <= `HDLCR_THR_RST;
      ovf_q <= 1'b0;
      inval_q <= 1'b0;
      abt_q <= 1'b0;
      ferr_q <= 1'b0;
      pkt_q <= 16'h0000;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      rd_ok_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      thr_q <= thr_d;
      ovf_q <= ovf_d;
      inval_q <= inval_d;
      abt_q <= abt_d;
      ferr_q <= ferr_d;
      pkt_q <= pkt_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      rd_ok_q <= rd_ok_d;
    end
  end

endmodule : hdlcr_top

/* verification/hdlcr_line_src.sv */
`timescale 1ns/100ps
module hdlcr_line_src (
  // overhead stream toward the receiver
  input wire logic pclk,
  output logic line_bit,
  output logic line_bit_en
);
  logic inv;
  logic ns;
  int ones;

  initial begin
    line_bit = 1'b0;
    line_bit_en = 1'b0;
    inv = 1'b0;
    ns = 1'b0;
    ones = 0;
  end

  task bit1(input logic v);
    @(posedge pclk);
    line_bit <= v ^ inv;
    line_bit_en <= 1'b1;
  endtask : bit1

  task flag;
    for (int i = 0; i < 8; i++) begin
      bit1(i != 0 && i != 7);
    end
    ones = 0;
  endtask : flag

  // ns lets a scenario leave every stuffed zero out while it is set
  task byt(input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      bit1(v[i]);
      ones = v[i] ? ones + 1 : 0;
      if (ones == 5 && !ns) begin
        bit1(1'b0);
        ones = 0;
      end
    end
  endtask : byt

  task fill(input int n);
    repeat (n) bit1(1'b1);
  endtask : fill

  // released line toggles so a stale level never passes for data
  task idle;
    repeat (6) begin
      @(posedge pclk);
      line_bit_en <= 1'b0;
      line_bit <= ~line_bit;
    end
  endtask : idle
endmodule : hdlcr_line_src

/* verification/hdlcr_assertions.sv */
`timescale 1ns/100ps
`include "hdlcr_cfg.svh"
module hdlcr_chk (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc;
  logic map;
  logic st_rd;
  logic [8:0] thr_q;
  logic [8:0] thr_d;
  logic [2:0] ctl_q;
  logic [2:0] ctl_d;

  assign acc = psel && penable;
  assign map = paddr inside {`HDLCR_OFF_CTRL, `HDLCR_OFF_THR, `HDLCR_OFF_STAT, `HDLCR_OFF_DATA, `HDLCR_OFF_CNT};
  assign st_rd = acc && !pwrite && paddr == `HDLCR_OFF_STAT;

  // shadow of the programmed threshold and control
  always_comb begin
    thr_d = thr_q;
    ctl_d = ctl_q;
    if (acc && pwrite && paddr == `HDLCR_OFF_THR) thr_d = pwdata[8:0];
    if (acc && pwrite && paddr == `HDLCR_OFF_CTRL) ctl_d = pwdata[2:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_q <= `HDLCR_THR_RST;
      ctl_q <= `HDLCR_CTRL_RST;
    end else begin
      thr_q <= thr_d;
      ctl_q <= ctl_d;
    end
  end

  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (acc && !map |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && map |-> !pslverr)
    else $error("mapped access refused");
  a_rdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  a_empty_lvl: assert property (st_rd |-> prdata[`HDLCR_ST_EMPTY] == (prdata[`HDLCR_ST_LVL +: 9] == 9'h000))
    else $error("empty flag disagrees with level");
  a_full_lvl: assert property (st_rd |-> prdata[`HDLCR_ST_FULL] == (prdata[`HDLCR_ST_LVL +: 9] == `HDLCR_DEPTH))
    else $error("full flag disagrees with level");
  a_avail_thr: assert property (st_rd |-> prdata[`HDLCR_ST_AVAIL] == (prdata[`HDLCR_ST_LVL +: 9] >= thr_q))
    else $error("data available flag disagrees with threshold");
  a_level_max: assert property (st_rd |-> prdata[`HDLCR_ST_LVL +: 9] <= `HDLCR_DEPTH)
    else $error("level beyond depth");
  a_ctrl_back: assert property (acc && !pwrite && paddr == `HDLCR_OFF_CTRL |-> prdata[2:0] == ctl_q)
    else $error("control readback wrong");
  a_thr_back: assert property (acc && !pwrite && paddr == `HDLCR_OFF_THR |-> prdata[8:0] == thr_q)
    else $error("threshold readback wrong");
endmodule : hdlcr_chk

bind hdlcr_top hdlcr_chk chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

/* verification/test_hdlc_overhead_receiver.sv */
`timescale 1ns/100ps
`include "hdlcr_cfg.svh"
module test_hdlc_overhead_receiver;
  typedef struct {
    logic [2:0] ctl;
    logic [7:0] base;
    int len;
    logic bad;
    int n;
  } hdlcr_row_t;
  // control, first byte, data bytes, corrupt check -> entries stored
  hdlcr_row_t rows[6] = '{'{3'h0, 8'h31, 4, 1'b0, 6}, '{3'h2, 8'h31, 5, 1'b0, 5}, '{3'h2, 8'h7E, 5, 1'b1, 5},
    '{3'h4, 8'h5A, 4, 1'b0, 6}, '{3'h3, 8'hF8, 6, 1'b0, 6}, '{3'h6, 8'hFF, 3, 1'b1, 3}};
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic line_bit;
  logic line_bit_en;
  logic err;
  logic [31:0] r;
  logic [15:0] c;
  logic [7:0] q[$];
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;

  hdlcr_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .line_bit, .line_bit_en);
  hdlcr_line_src src (.pclk, .line_bit, .line_bit_en);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] rev8(input logic [7:0] b);
    rev8 = {<<{b}};
  endfunction : rev8

  // reflected crc over q, sent inverted
  task mk(input logic [7:0] b, input int n, input logic bad);
    q.delete();
    for (int i = 0; i < n; i++) q.push_back(8'(b + 17 * i));
    c = 16'hFFFF;
    foreach (q[i]) for (int k = 0; k < 8; k++) c = (c[0] ^ q[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    c = ~c ^ {15'h0, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask : mk

  // one flag closes each packet and opens the next
  task send(input int part, input int nf);
    src.flag();
    repeat (nf) begin
      foreach (q[i]) src.byt(q[i], (part != 0 && i == q.size() - 1) ? part : 8);
      src.flag();
    end
    src.fill(16);
    src.idle();
  endtask : send

  task stat(input logic [8:0] n);
    apb(1'b0, `HDLCR_OFF_STAT, 32'h0);
    chk({23'h0, r[24:16]}, {23'h0, n});
  endtask : stat

  task pop(input logic [15:0] e);
    apb(1'b0, `HDLCR_OFF_DATA, 32'h0);
    chk(r & 32'h0000_8FFF, {16'h0, e});
  endtask : pop

  task pops(input int n, input logic ab);
    for (int i = 0; i < n; i++) pop({5'h0, ab && i == n - 1, i == n - 1, i == 0, q[i]});
  endtask : pops

  task rst_chk;
    stat(9'h000);
    chk(r & 32'h0000_007F, 32'h0000_0001);
    apb(1'b0, `HDLCR_OFF_CTRL, 32'h0);
    chk(r & 32'h0000_0007, 32'h0);
    apb(1'b0, `HDLCR_OFF_THR, 32'h0);
    chk(r & 32'h0000_01FF, 32'h0000_0010);
  endtask : rst_chk

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rst_chk();
    apb(1'b1, `HDLCR_OFF_THR, 32'h0000_0005);
    foreach (rows[k]) begin
      apb(1'b1, `HDLCR_OFF_CTRL, {29'h0, rows[k].ctl});
      src.inv = rows[k].ctl[0];
      mk(rows[k].base, rows[k].len, rows[k].bad);
      send(0, 1);
      stat(9'(rows[k].n));
      for (int i = 0; i < rows[k].n; i++)
        pop({4'h0, rows[k].bad && rows[k].ctl[1] && i == rows[k].n - 1, 1'b0, i == rows[k].n - 1, i == 0,
          rows[k].ctl[2] ? rev8(q[i]) : q[i]});
    end
    apb(1'b1, `HDLCR_OFF_CTRL, 32'h0);
    src.inv = 1'b0;
    apb(1'b0, `HDLCR_OFF_DATA, 32'h0);
    chk(r & 32'h0000_8000, 32'h0000_8000);
    stat(9'h000);
    apb(1'b0, 12'h020, 32'h0);
    chk({31'h0, err}, 32'h1);
    q = '{8'hA5};
    send(0, 1);
    stat(9'h000);
    mk(8'h21, 2, 1'b0);
    send(0, 2);
    stat(9'h008);
    pops(4, 1'b0);
    pops(4, 1'b0);
    // end flag and start flag sharing one zero, then a plain back-to-back flag
    src.flag();
    foreach (q[i]) src.byt(q[i], 8);
    src.ns = 1'b1;
    src.byt(8'h7E, 8);
    src.byt(8'h3F, 7);
    src.ns = 1'b0;
    send(0, 1);
    stat(9'h008);
    pops(4, 1'b0);
    pops(4, 1'b0);
    q = '{8'h12, 8'h34, 8'hF8};
    src.ns = 1'b1;
    send(0, 1);
    src.ns = 1'b0;
    stat(9'h003);
    pops(3, 1'b0);
    mk(8'h01, 2, 1'b0);
    src.flag();
    foreach (q[i]) src.byt(q[i], 8);
    src.fill(23);
    src.idle();
    stat(9'h002);
    pops(2, 1'b1);
    mk(8'h01, 3, 1'b0);
    send(3, 1);
    stat(9'h002);
    pops(2, 1'b1);
    apb(1'b0, `HDLCR_OFF_STAT, 32'h0);
    chk(r & 32'h0000_0030, 32'h0000_0030);
    apb(1'b1, `HDLCR_OFF_STAT, 32'h0000_0078);
    apb(1'b0, `HDLCR_OFF_STAT, 32'h0);
    chk(r & 32'h0000_0078, 32'h0);
    q.delete();
    for (int i = 0; i < 260; i++) q.push_back(8'(i));
    send(0, 2);
    stat(9'h100);
    chk(r & 32'h0000_000C, 32'h0000_000C);
    pops(256, 1'b1);
    stat(9'h000);
    mk(8'h40, 2, 1'b0);
    send(0, 1);
    stat(9'h004);
    pops(4, 1'b0);
    apb(1'b1, `HDLCR_OFF_CNT, 32'h0);
    send(0, 1);
    apb(1'b0, `HDLCR_OFF_CNT, 32'h0);
    chk(r & 32'h0000_FFFF, 32'h0000_0001);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rst_chk();
    give_verdict();
  end
endmodule : test_hdlc_overhead_receiver
